// File: core/ssp_cfg.svh
// Named constants for the sensor serial register port: timings, field positions and reset values.
// Assumes a 200 MHz system clock on both ends and a 3000 frame/s frame clock in the sensor.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ==========================================================================
// Clock and frame rates
`define SSP_MCLK_MHZ             200
`define SSP_FRAMES_PER_S         3000
`define SSP_FRAME_CYC            ((`SSP_MCLK_MHZ * 1000000) / `SSP_FRAMES_PER_S)

// ==========================================================================
// Link timing, each time in its own unit, with a cycle count beside all but the settling frames and the clock half period
`define SSP_RESYNC_LOW_TIME_NS   1000
`define SSP_RESYNC_CYC           ((`SSP_RESYNC_LOW_TIME_NS * `SSP_MCLK_MHZ + 999) / 1000)
`define SSP_PORT_WATCHDOG_TIME_US 1700
`define SSP_WDOG_CYC             (`SSP_PORT_WATCHDOG_TIME_US * `SSP_MCLK_MHZ)
`define SSP_SLEEP_ENTRY_TIME_US  666
`define SSP_SLEEP_CYC            (`SSP_SLEEP_ENTRY_TIME_US * `SSP_MCLK_MHZ)
`define SSP_WAKE_TO_VALID_TIME_US 3000
`define SSP_WAKE_CYC             (`SSP_WAKE_TO_VALID_TIME_US * `SSP_MCLK_MHZ)
`define SSP_SUPPLY_TO_VALID_TIME_US 3000
`define SSP_SUPPLY_CYC           (`SSP_SUPPLY_TO_VALID_TIME_US * `SSP_MCLK_MHZ)
`define SSP_SETTLE_FRAMES        90
`define SSP_SCLK_HALF_CYC        16

// ==========================================================================
// Frame layout and register fields
`define SSP_CNT_W                20
`define SSP_BIT_W                4
`define SSP_LAST_BIT             3'h7
`define SSP_LAST_XFER_BIT        4'hf
`define SSP_ADDR_LAST_BIT        4'h7
`define SSP_OPMODE_ADDR          7'h0a
`define SSP_SLEEP_REQUEST_BIT    6
`define SSP_REG_RESET            8'h00
`define SSP_DIR_WRITE            1'b1
`define SSP_IDLE_LEVEL           1'b1

`endif

// File: core/ssp_pkg.sv
// Types shared by both ends of the sensor serial register port.
// Assumes ssp_cfg.svh holds every number; this package holds only enumerations.
package ssp_pkg;

   // ==========================================================================
   // Sensor end: one state per byte role, Gray along both branches.
   typedef enum logic [1:0]
   {
      SSP_DEV_ADDR  = 2'h0,
      SSP_DEV_RDATA = 2'h1,
      SSP_DEV_WDATA = 2'h2
   } ssp_dev_st_t;

   // ==========================================================================
   // Controller end: transfer path idle, low, high, wait is Gray coded.
   typedef enum logic [2:0]
   {
      SSP_HST_IDLE  = 3'h0,
      SSP_HST_LOW   = 3'h1,
      SSP_HST_HIGH  = 3'h3,
      SSP_HST_WAIT  = 3'h2,
      SSP_HST_RSLOW = 3'h4,
      SSP_HST_RSHI  = 3'h5
   } ssp_hst_st_t;

endpackage : ssp_pkg

// File: core/ssp_link_if.sv
// Two-wire link between the controller and the sensor: clock and shared data line.
// Assumes a pull-up on the data line; the wire level is resolved here from both enables.
`timescale 1ns/1ps

interface ssp_link_if;

   logic sclk;
   logic host_sdio_o;
   logic host_sdio_oe;
   logic dev_sdio_o;
   logic dev_sdio_oe;
   logic sdio;

   // Resolved data line; with neither end driving, the pull-up wins.
   assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

   modport host (output sclk, output host_sdio_o, output host_sdio_oe, input sdio);
   modport dev  (input sclk, output dev_sdio_o, output dev_sdio_oe, input sdio);

endinterface : ssp_link_if

// File: core/ssp_dev.sv
// Sensor end of the serial register port: register file, port watchdog and power-down timing.
// Assumes the controller drives the clock and that the clock and data pins are asynchronous to mclk.
`timescale 1ns/1ps
`include "ssp_cfg.svh"

// Summary of operation
// R01 - Controller always makes the clock.
// R02 - Only the controller starts transfers.
// R03 - Driver changes data only after falling clock.
// R04 - Two bytes: direction plus address, then data.
// R05 - Write: direction one, controller sends data.
// R06 - Sensor samples every write bit on rising.
// R07 - Clock low then high resyncs via watchdog.
// R08 - Power-down entry completes within two frames.
// R09 - Valid motion 3 to 30.5 ms after wake.
// R10 - Moved while asleep: 90 more settling frames.
// R11 - Valid motion 3 to 30.5 ms after power-up.
// R12 - Read: controller releases, sensor drives data.
// R13 - Sensor drives after falling, releases on rising.
// R14 - Watchdog resets port only, keeps registers.
// R15 - Watchdog disabled in power-down, access works.
// R16 - Bits travel most significant first.
// R17 - Write commits after the sixteenth bit.
module ssp_dev
   import ssp_pkg::*;
#(
   parameter int WDOG_CYC   = `SSP_WDOG_CYC,
   parameter int FRAME_CYC  = `SSP_FRAME_CYC,
   parameter int SUPPLY_CYC = `SSP_SUPPLY_CYC,
   parameter int WAKE_CYC   = `SSP_WAKE_CYC,
   parameter int SETTLE_FR  = `SSP_SETTLE_FRAMES
)
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   ssp_link_if.dev         link,
   input  wire logic       motion_i,
   output logic            sleep_o,
   output logic            motion_valid_o,
   output logic            settle_o,
   output logic            wr_stb_o,
   output logic [6:0]      wr_addr_o,
   output logic [7:0]      wr_data_o
);

   localparam int CW = `SSP_CNT_W;

   logic              sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic              sdio_s1_q, sdio_s2_q;
   logic              sdo_q, oe_q;
   ssp_dev_st_t       st_q;
   logic [2:0]        bit_q;
   logic [7:0]        sh_q, tx_q, wr_data_q;
   logic [6:0]        addr_q, settle_q, wr_addr_q;
   logic [CW-1:0]     wd_cnt_q, fr_cnt_q, val_cnt_q;
   logic              moved_q, settle_act_q;
   logic              sleep_q, valid_q, wr_stb_q;
   logic [7:0]        mem_q [0:127];

   // ==========================================================================
   // Pin synchronisers; the third clock stage exists only for edge detection.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         {sclk_s1_q, sclk_s2_q, sclk_s3_q, sdio_s1_q, sdio_s2_q} <= {5{`SSP_IDLE_LEVEL}};
      else
      begin
         {sclk_s1_q, sclk_s2_q, sclk_s3_q} <= {link.sclk, sclk_s1_q, sclk_s2_q}; // [R01]
         {sdio_s1_q, sdio_s2_q}            <= {link.sdio, sdio_s1_q};
      end
   end

   // ==========================================================================
   // Edge, byte-boundary and watchdog decode.
   wire       rise      = sclk_s2_q & ~sclk_s3_q;
   wire       fall      = ~sclk_s2_q & sclk_s3_q;
   wire [7:0] in_byte   = {sh_q[6:0], sdio_s2_q};             // [R16]
   wire       last_bit  = (bit_q == `SSP_LAST_BIT);
   wire       addr_done = (st_q == SSP_DEV_ADDR) & rise & last_bit;
   wire       commit    = (st_q == SSP_DEV_WDATA) & rise & last_bit;
   wire       sleep_bit = mem_q[`SSP_OPMODE_ADDR][`SSP_SLEEP_REQUEST_BIT];
   wire       wd_expire = sclk_s2_q & ~sleep_bit & (wd_cnt_q >= CW'(WDOG_CYC - 1)); // [R07] [R15]
   wire       fr_tick   = (fr_cnt_q == CW'(FRAME_CYC - 1));
   wire [7:0] rd_byte   = mem_q[in_byte[6:0]];

   // ==========================================================================
   // Watchdog counts mclk cycles since the last clock edge; any edge restarts it.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         wd_cnt_q <= '0;
      else if (rise | fall)
         wd_cnt_q <= '0;
      else if (wd_cnt_q != {CW{1'b1}})
         wd_cnt_q <= wd_cnt_q + 1'b1;
   end

   // ==========================================================================
   // Port state machine. The sensor never leaves the address state on its own, so it cannot start a transfer.
   always_ff @(posedge mclk)
   begin
      if (!rst_n || wd_expire)
      begin
         st_q   <= SSP_DEV_ADDR;      // [R14] [R02]
         bit_q  <= '0;
         sh_q   <= '0;
         tx_q   <= '0;
         addr_q <= '0;
         sdo_q  <= `SSP_IDLE_LEVEL;
         oe_q   <= 1'b0;
      end
      else
      begin
         case (st_q)
            SSP_DEV_ADDR:
            begin
               if (rise)
               begin
                  sh_q  <= in_byte;   // [R06]
                  bit_q <= bit_q + 1'b1;
               end
               if (addr_done)
               begin
                  addr_q <= in_byte[6:0];
                  tx_q   <= rd_byte;
                  st_q   <= (in_byte[7] == `SSP_DIR_WRITE) ? SSP_DEV_WDATA : SSP_DEV_RDATA; // [R04] [R05] [R12]
               end
            end
            SSP_DEV_WDATA:
            begin
               if (rise)
               begin
                  sh_q  <= in_byte;   // [R06]
                  bit_q <= bit_q + 1'b1;
               end
               if (commit)
                  st_q <= SSP_DEV_ADDR;
            end
            SSP_DEV_RDATA:
            begin
               if (fall)
               begin
                  sdo_q <= tx_q[7];   // [R03] [R13] [R16]
                  tx_q  <= {tx_q[6:0], 1'b0};
                  oe_q  <= 1'b1;
               end
               if (rise)
               begin
                  bit_q <= bit_q + 1'b1;
                  if (last_bit)
                  begin
                     oe_q <= 1'b0;    // [R13]
                     st_q <= SSP_DEV_ADDR;
                  end
               end
            end
            default:
               st_q <= SSP_DEV_ADDR;
         endcase
      end
   end

   // ==========================================================================
   // Register file, one entry per generate step; a watchdog expiry never touches it.
   generate
      for (genvar gi = 0; gi < 128; gi = gi + 1)
      begin : g_reg
         always_ff @(posedge mclk)
         begin
            if (!rst_n)
               mem_q[gi] <= `SSP_REG_RESET;
            else if (commit && addr_q == 7'(gi))
               mem_q[gi] <= in_byte;  // [R17] [R14]
         end
      end
   endgenerate

   // ==========================================================================
   // Write notification to the sensor core, one cycle wide, and the settling flag held in its own flip-flop.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         {wr_stb_q, settle_act_q} <= 2'b00;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end
      else
      begin
         {wr_stb_q, settle_act_q} <= {commit, (settle_q != '0)}; // [R17] [R10]
         if (commit)
         begin
            wr_addr_q <= addr_q;
            wr_data_q <= in_byte;
         end
      end
   end

   // ==========================================================================
   // Frame clock; entry into power-down waits for the next frame boundary, one frame at most.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         fr_cnt_q <= '0;
      else if (fr_tick)
         fr_cnt_q <= '0;
      else
         fr_cnt_q <= fr_cnt_q + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         sleep_q <= 1'b0;
      else if (!sleep_bit)
         sleep_q <= 1'b0;
      else if (fr_tick)
         sleep_q <= 1'b1;             // [R08]
   end

   // ==========================================================================
   // Valid-data delay after power-up and after wake; both start the same counter.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         val_cnt_q <= CW'(SUPPLY_CYC - 1); // [R11]
         valid_q   <= 1'b0;
      end
      else if (sleep_q)
      begin
         val_cnt_q <= CW'(WAKE_CYC - 1);   // [R09]
         valid_q   <= 1'b0;
      end
      else if (val_cnt_q != '0)
         val_cnt_q <= val_cnt_q - 1'b1;
      else
         valid_q <= 1'b1;             // [R09] [R11]
   end

   // ==========================================================================
   // Motion seen while asleep buys extra exposure-settling frames once data is valid again.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         moved_q  <= 1'b0;
         settle_q <= '0;
      end
      else if (sleep_q)
         moved_q <= moved_q | motion_i;
      else if (moved_q && valid_q)
      begin
         moved_q  <= 1'b0;
         settle_q <= 7'(SETTLE_FR);   // [R10]
      end
      else if (fr_tick && settle_q != '0)
         settle_q <= settle_q - 1'b1;
   end

   // ==========================================================================
   // Outputs, each straight from a flip-flop.
   assign link.dev_sdio_o  = sdo_q;
   assign link.dev_sdio_oe = oe_q;
   assign sleep_o          = sleep_q;
   assign motion_valid_o   = valid_q;
   assign settle_o         = settle_act_q;
   assign wr_stb_o         = wr_stb_q;
   assign wr_addr_o        = wr_addr_q;
   assign wr_data_o        = wr_data_q;

endmodule : ssp_dev

// File: core/ssp_host.sv
// Controller end of the serial register port: clock generation, transfers, resync and power waits.
// Assumes the user holds request inputs steady while busy is low and pulses req_i for one cycle.
`timescale 1ns/1ps
`include "ssp_cfg.svh"

module ssp_host
   import ssp_pkg::*;
#(
   parameter int HALF_CYC  = `SSP_SCLK_HALF_CYC,
   parameter int RSYNC_CYC = `SSP_RESYNC_CYC,
   parameter int WDOG_CYC  = `SSP_WDOG_CYC,
   parameter int SLEEP_CYC = `SSP_SLEEP_CYC,
   parameter int WAKE_CYC  = `SSP_WAKE_CYC
)
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   ssp_link_if.host        link,
   input  wire logic       req_i,
   input  wire logic       req_write_i,
   input  wire logic [6:0] req_addr_i,
   input  wire logic [7:0] req_wdata_i,
   input  wire logic       resync_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [7:0]      rdata_o
);

   localparam int CW = `SSP_CNT_W;

   ssp_hst_st_t       st_q;
   logic              sclk_q, sdo_q, oe_q, wr_q, asleep_q;
   logic              busy_q, done_q;
   logic [`SSP_BIT_W-1:0] bit_q;
   logic [15:0]       tx_q;
   logic [7:0]        rx_q, rdata_q;
   logic [CW-1:0]     cnt_q;
   logic              sdio_s1_q, sdio_s2_q;

   // ==========================================================================
   // Decode of the current step.
   wire        cnt_done  = (cnt_q == '0);
   wire [15:0] frame     = {req_write_i, req_addr_i, req_wdata_i};
   wire        is_opmode = (tx_q[14:8] == `SSP_OPMODE_ADDR);
   wire        sleep_set = wr_q & is_opmode & tx_q[`SSP_SLEEP_REQUEST_BIT];
   wire        wake_set  = wr_q & is_opmode & ~tx_q[`SSP_SLEEP_REQUEST_BIT] & asleep_q;
   wire        drive_bit = wr_q | (bit_q <= `SSP_ADDR_LAST_BIT);

   // ==========================================================================
   // Read data is a pin from the far end, so it is synchronised first.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sdio_s1_q <= `SSP_IDLE_LEVEL;
         sdio_s2_q <= `SSP_IDLE_LEVEL;
      end
      else
      begin
         sdio_s1_q <= link.sdio;
         sdio_s2_q <= sdio_s1_q;
      end
   end

   // ==========================================================================
   // Transfer sequencer. The opmode data byte is kept in tx_q low bits by a rotate, so waits can see it.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         st_q     <= SSP_HST_IDLE;
         sclk_q   <= `SSP_IDLE_LEVEL;
         sdo_q    <= `SSP_IDLE_LEVEL;
         oe_q     <= 1'b1;
         wr_q     <= 1'b0;
         asleep_q <= 1'b0;
         bit_q    <= '0;
         tx_q     <= '0;
         rx_q     <= '0;
         rdata_q  <= '0;
         cnt_q    <= '0;
         done_q   <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (!cnt_done)
            cnt_q <= cnt_q - 1'b1;
         case (st_q)
            SSP_HST_IDLE:
            begin
               if (resync_i)
               begin
                  sclk_q <= 1'b0;     // [R07]
                  cnt_q  <= CW'(RSYNC_CYC - 1);
                  st_q   <= SSP_HST_RSLOW;
               end
               else if (req_i)
               begin
                  sclk_q <= 1'b0;     // [R01] [R02]
                  sdo_q  <= frame[15]; // [R05] [R12] [R16]
                  oe_q   <= 1'b1;
                  tx_q   <= {frame[14:0], frame[15]};
                  wr_q   <= req_write_i;
                  bit_q  <= '0;
                  cnt_q  <= CW'(HALF_CYC - 1);
                  st_q   <= SSP_HST_LOW;
               end
            end
            SSP_HST_LOW:
            begin
               if (cnt_done)
               begin
                  sclk_q <= 1'b1;
                  cnt_q  <= CW'(HALF_CYC - 1);
                  st_q   <= SSP_HST_HIGH;
                  if (!drive_bit)
                     rx_q <= {rx_q[6:0], sdio_s2_q}; // [R13]
               end
            end
            SSP_HST_HIGH:
            begin
               if (cnt_done)
               begin
                  if (!wr_q && bit_q == `SSP_ADDR_LAST_BIT)
                     oe_q <= 1'b0;    // [R12]
                  if (bit_q == `SSP_LAST_XFER_BIT)
                  begin
                     oe_q    <= 1'b1; // [R13]
                     sdo_q   <= `SSP_IDLE_LEVEL;
                     rdata_q <= rx_q;
                     st_q    <= SSP_HST_WAIT;
                     cnt_q   <= sleep_set ? CW'(SLEEP_CYC - 1) :
                                (wake_set ? CW'(WAKE_CYC - 1) : '0); // [R08]
                     if (sleep_set)
                        asleep_q <= 1'b1;
                     else if (wake_set)
                        asleep_q <= 1'b0;
                  end
                  else
                  begin
                     sclk_q <= 1'b0;
                     sdo_q  <= tx_q[15];  // [R03]
                     tx_q   <= {tx_q[14:0], tx_q[15]};
                     bit_q  <= bit_q + 1'b1;
                     cnt_q  <= CW'(HALF_CYC - 1);
                     st_q   <= SSP_HST_LOW;
                  end
               end
            end
            SSP_HST_WAIT:
            begin
               if (cnt_done)
               begin
                  done_q <= 1'b1;
                  st_q   <= SSP_HST_IDLE;
               end
            end
            SSP_HST_RSLOW:
            begin
               if (cnt_done)
               begin
                  sclk_q <= 1'b1;     // [R07]
                  cnt_q  <= CW'(WDOG_CYC - 1);
                  st_q   <= SSP_HST_RSHI;
               end
            end
            SSP_HST_RSHI:
            begin
               if (cnt_done)
               begin
                  done_q <= 1'b1;
                  st_q   <= SSP_HST_IDLE;
               end
            end
            default:
               st_q <= SSP_HST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Busy rises as the sequencer leaves idle and falls a cycle after it returns; it comes from its own flip-flop.
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         busy_q <= 1'b0;
      else
         busy_q <= (st_q != SSP_HST_IDLE) | ((st_q == SSP_HST_IDLE) & (req_i | resync_i));
   end

   assign link.sclk         = sclk_q;
   assign link.host_sdio_o  = sdo_q;
   assign link.host_sdio_oe = oe_q;
   assign busy_o            = busy_q;
   assign done_o            = done_q;
   assign rdata_o           = rdata_q;

endmodule : ssp_host

// File: tb/ssp_link_props.sv
// Checker for the two-wire link between controller and sensor.
// Assumes plain copies of the interface signals and the host's half-period and resync counts.
`timescale 1ns/1ps

module ssp_link_props #(
   parameter int HALF_CYC  = 16,
   parameter int RSYNC_CYC = 200
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic host_sdio_o,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_o,
   input wire logic dev_sdio_oe,
   input wire logic sdio
);
   // ==========================================================================
   // Helper counters
   logic [15:0] low_q;
   logic [15:0] low_d;
   logic [7:0]  high_q;
   logic [7:0]  high_d;
   logic [3:0]  rise_q;
   logic [3:0]  rise_d;
   logic        sclk_q;

   // Low time, saturating high time and clock rises while the sensor drives.
   assign low_d  = sclk ? 16'h0000 : low_q + 16'h0001;
   assign high_d = !sclk ? 8'h00 : (high_q == 8'hff ? high_q : high_q + 8'h01);
   assign rise_d = !dev_sdio_oe ? 4'h0 : rise_q + {3'h0, sclk & ~sclk_q};

   // Registers restart with reset so a second reset cannot leave stale counts.
   always_ff @(posedge mclk)
   begin
      low_q  <= rst_n ? low_d : 16'h0000;
      high_q <= rst_n ? high_d : 8'h00;
      rise_q <= rst_n ? rise_d : 4'h0;
      sclk_q <= rst_n ? sclk : 1'b1;
   end

   // ==========================================================================
   // Link properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive the data line");
   a_stable_at_rise: assert property ($rose(sclk) |-> $stable(sdio) && $past(sdio, 2) == $past(sdio, 1))
      else $error("data line moved close to a rising clock");
   a_dev_drive_low: assert property ($rose(dev_sdio_oe) |-> !sclk)
      else $error("sensor began driving while clock high");
   a_dev_after_host: assert property ($rose(dev_sdio_oe) |-> !$past(host_sdio_oe, 2))
      else $error("sensor drove before controller released");
   a_dev_release_high: assert property ($fell(dev_sdio_oe) |-> sclk)
      else $error("sensor released while clock low");
   a_dev_byte_len: assert property ($fell(dev_sdio_oe) |-> rise_q == 4'h8)
      else $error("sensor drove other than eight bits");
   a_low_phase_len: assert property ($rose(sclk) |-> (low_q >= HALF_CYC - 1 && low_q <= HALF_CYC + 1)
      || low_q >= RSYNC_CYC - 1)
      else $error("clock low phase of wrong length");
   a_idle_line_high: assert property (high_q == 8'hff |-> host_sdio_oe && host_sdio_o && !dev_sdio_oe)
      else $error("idle line not driven high by controller");

endmodule : ssp_link_props

// File: tb/sensor_serial_register_port_test.sv
// Self-checking bench: controller and sensor ends joined, checked against a register model.
// Assumes shortened frame, wake and watchdog counts set on the instances below.
`timescale 1ns/1ps

module sensor_serial_register_port_test;
   // ==========================================================================
   // Stimulus, outputs and model
   logic        mclk = 0, rst_n = 0, req_i = 0, req_write_i = 0, resync_i = 0, motion_i = 0;
   logic [6:0]  req_addr_i = 7'h00;
   logic [7:0]  req_wdata_i = 8'h00;
   logic        busy_o, done_o, sleep_o, motion_valid_o, settle_o, wr_stb_o;
   logic [7:0]  rdata_o, wr_data_o;
   logic [6:0]  wr_addr_o, ad[6];
   logic [15:0] wq[$];
   int          n_mismatch = 0, n_compared = 0, mem[128], i, cnt;
   integer      seed;

   // Shortened counts; the host watchdog wait must outlast the sensor's, and its sleep wait a frame.
   localparam int HALF_C = 16, RSYNC_C = 200, WD_HOST_C = 250, WD_DEV_C = 200;
   localparam int SLEEP_C = 60, FRAME_C = 50, VAL_C = 100, SETTLE_C = 3;

   ssp_link_if link ();
   ssp_host #(.HALF_CYC(HALF_C), .RSYNC_CYC(RSYNC_C), .WDOG_CYC(WD_HOST_C), .SLEEP_CYC(SLEEP_C),
      .WAKE_CYC(VAL_C)) ssp_host_inst (
      .mclk(mclk), .rst_n(rst_n), .link(link), .req_i(req_i), .req_write_i(req_write_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .resync_i(resync_i),
      .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
   ssp_dev #(.WDOG_CYC(WD_DEV_C), .FRAME_CYC(FRAME_C), .SUPPLY_CYC(VAL_C), .WAKE_CYC(VAL_C),
      .SETTLE_FR(SETTLE_C)) ssp_dev_inst (
      .mclk(mclk), .rst_n(rst_n), .link(link), .motion_i(motion_i), .sleep_o(sleep_o),
      .motion_valid_o(motion_valid_o), .settle_o(settle_o), .wr_stb_o(wr_stb_o),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
   ssp_link_props #(.HALF_CYC(HALF_C), .RSYNC_CYC(RSYNC_C)) ssp_link_props_inst (
      .mclk(mclk), .rst_n(rst_n), .sclk(link.sclk), .host_sdio_o(link.host_sdio_o),
      .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
      .dev_sdio_oe(link.dev_sdio_oe), .sdio(link.sdio));

   // Clock, and a log of committed writes since the strobe lasts one cycle only.
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) if (wr_stb_o === 1'b1) wq.push_back({1'b0, wr_addr_o, wr_data_o});

   // ==========================================================================
   // Tasks
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Bounded wait for the one-cycle completion pulse.
   task automatic wait_done;
      for (int k = 0; k < 2000; k++)
      begin
         @(posedge mclk);
         #1;
         if (done_o === 1'b1) return;
      end
      n_mismatch++;
      final_report;
   endtask : wait_done

   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] e;
      @(negedge mclk);
      {req_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
      @(negedge mclk);
      req_i = 0;
      chk("busy", 16'h0001, {15'h0000, busy_o});
      wait_done;
      if (w)
      begin
         mem[a] = d;
         chk("write count", 16'h0001, 16'(wq.size()));
         e = wq.size() ? wq.pop_front() : 16'hffff;
         chk("write addr data", {1'b0, a, d}, e);
      end
      else
         chk("read data", 16'(mem[a]), {8'h00, rdata_o});
   endtask : xfer

   // ==========================================================================
   // Main sequence
   initial
   begin
      seed = 32'h821b;
      foreach (mem[j]) mem[j] = 0;
      repeat (8) @(negedge mclk);
      rst_n = 1;
      for (cnt = 0; motion_valid_o !== 1'b1 && cnt < 400; cnt++) @(negedge mclk);
      chk("supply delay", 16'h0001, {15'h0000, cnt >= VAL_C - 5 && cnt <= VAL_C + 10});
      chk("rdata reset", 16'h0000, {8'h00, rdata_o});
      $display("test power_up done");
      for (i = 0; i < 6; i++)
      begin
         ad[i] = i == 0 ? 7'h00 : (i == 1 ? 7'h7f : 7'($random(seed)));
         if (ad[i] == 7'h0a) ad[i] = 7'h0b;
         xfer(1, ad[i], 8'($random(seed)));
      end
      xfer(0, 7'h0a, 8'h00);
      for (i = 0; i < 6; i++) xfer(0, ad[i], 8'h00);
      $display("test write_read done");
      @(negedge mclk);
      resync_i = 1;
      @(negedge mclk);
      resync_i = 0;
      wait_done;
      xfer(0, ad[2], 8'h00);
      xfer(1, ad[3], 8'h5a);
      xfer(0, ad[3], 8'h00);
      $display("test resync done");
      xfer(1, 7'h0a, 8'h40);
      chk("sleep entered", 16'h0001, {15'h0000, sleep_o});
      @(negedge mclk);
      motion_i = 1;
      xfer(0, 7'h0a, 8'h00);
      xfer(1, ad[4], 8'ha5);
      xfer(0, ad[4], 8'h00);
      @(negedge mclk);
      motion_i = 0;
      fork
         xfer(1, 7'h0a, 8'h00);
         begin
            for (cnt = 0; sleep_o !== 1'b0 && cnt < 2000; cnt++) @(negedge mclk);
            chk("sleep left", 16'h0001, {15'h0000, cnt < 2000});
            chk("valid after wake", 16'h0000, {15'h0000, motion_valid_o});
            for (cnt = 0; motion_valid_o !== 1'b1 && cnt < 400; cnt++) @(negedge mclk);
            chk("wake delay", 16'h0001, {15'h0000, cnt >= VAL_C - 5 && cnt <= VAL_C + 10});
            // The settling flag is raised a cycle after valid and registered once more.
            repeat (3) @(negedge mclk);
            chk("settling", 16'h0001, {15'h0000, settle_o});
         end
      join
      repeat (200) @(negedge mclk);
      chk("settling over", 16'h0000, {15'h0000, settle_o});
      $display("test power_down done");
      final_report;
   end

endmodule : sensor_serial_register_port_test
